// ---- flash_ctrl_cfg.svh ----
`ifndef FLASH_CTRL_CFG_SVH
`define FLASH_CTRL_CFG_SVH

// ==========================================================
// register byte offsets
`define OFS_CURRENT_ONE     8'h00
`define OFS_CURRENT_TWO     8'h04
`define OFS_REDUCED_CURRENT 8'h08
`define OFS_CONTROL         8'h0c
`define OFS_LIMITS          8'h10
`define OFS_ACTUAL          8'h14
`define OFS_MINIMUM         8'h18
`define OFS_IRQ_STATUS      8'h1c
`define OFS_IRQ_MASK        8'h20
`define OFS_STATE           8'h24

// ==========================================================
// control field positions
`define CTL_MODE_LSB        0
`define CTL_OUT_ON          2
`define CTL_PINFN_LSB       3
`define CTL_TRIG_USE        5
`define CTL_TRIG_LEVEL      6
`define CTL_BLOCK_LOWBAT    7
`define CTL_DUTY_LSB        8

// ==========================================================
// status bit positions
`define ST_LOWBAT           0
`define ST_TXMASK           1
`define ST_TIMEOUT          2
`define ST_IDLE_OFF         3

// ==========================================================
// reset values
`define RST_CURRENT         8'h00
`define RST_REDUCED         8'h00
`define RST_CONTROL         12'h000
`define RST_DURATION        16'h0064
`define RST_DUTY            4'h0

// ==========================================================
// timing
`define CLK_PERIOD_NS       10
`define PWM_FREQ_HZ         31250
`define PWM_PERIOD_CYC      (1000000000 / (`PWM_FREQ_HZ * `CLK_PERIOD_NS))
`define STEP_TIME_NS        8000
`define STEP_CYC            (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define IDLE_TIME_NS        100000000
`define IDLE_CYC            (`IDLE_TIME_NS / `CLK_PERIOD_NS)
`define DUR_UNIT_NS         100000
`define DUR_UNIT_CYC        (`DUR_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ---- flash_ctrl_pkg.sv ----
package flash_ctrl_pkg;

    typedef enum logic [1:0] {
        mode_standby,
        mode_indicator,
        mode_assist,
        mode_flash
    } mode_e;

    typedef enum {
        st_idle,
        st_wait_trig,
        st_flash,
        st_done
    } flash_st_e;

    typedef struct packed {
        logic [3:0] duty;
        logic       block_lowbat;
        logic       trig_level;
        logic       trig_use;
        logic [1:0] pin_fn;
        logic       out_on;
        logic [1:0] mode;
    } control_s;

    typedef struct packed {
        logic torch;
        logic trig;
        logic txmask;
        logic scl;
        logic bat_low_pre;
        logic bat_low_run;
    } pins_s;

endpackage

// ---- flash_ctrl.sv ----
// Operation
// - idle clock low for timeout in active modes forces shutdown and register defaults
// - mode 00 with pin function 10 follows torch pin using seven bits
// - mode 01 enabled runs pwm at 31.25kHz with programmed duty
// - low current pwm uses only six low current bits
// - mode 10 enabled runs assist with seven low current bits
// - flash with pin function 01 and mask high uses reduced current
// - prestart battery check below threshold sets low battery flag
// - failed check with blocking set prevents flash, stays off
// - failed check without blocking runs flash at reduced current
// - runtime low battery reduces current or halts ramp, sets flag
// - undervoltage current change one step every 8us
// - current code in use is readable during flash
// - lowest code of a pulse stays readable after it
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"

module flash_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int IDLE_CYCLES = `IDLE_CYC,
    parameter int UNIT_CYCLES = `DUR_UNIT_CYC
) (
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire pins_s       pins_in,
    output logic [7:0]       sink_code_out,
    output logic             sink_on_out,
    output logic [1:0]       mode_out,
    output logic             irq_out
);

    localparam int PWM_CYC  = `PWM_PERIOD_CYC;
    localparam int STEP_CYC = `STEP_CYC;

    // ==========================================================
    // registers
    logic [7:0]  cur_one_ff;
    logic [7:0]  current_setting_two_ff;
    logic [7:0]  reduced_ff;
    control_s    ctl_ff;
    logic [15:0] duration_ff;
    logic [7:0]  actual_ff;
    logic [7:0]  minimum_ff;
    logic [3:0]  status_ff;
    logic [3:0]  mask_ff;
    flash_st_e   fst_ff;
    logic [31:0] idle_cnt_ff;
    logic [15:0] pwm_cnt_ff;
    logic [15:0] step_cnt_ff;
    logic [31:0] dur_cnt_ff;
    logic [15:0] units_ff;
    logic        trig_d_ff;
    logic        tx_seen_ff;

    // ==========================================================
    // bus handshake
    logic        aw_ff;
    logic        w_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        do_write;
    logic        do_read;
    logic [31:0] rd_val;
    logic [3:0]  nxt_status;
    logic [3:0]  set_ev;
    logic        idle_fire;
    logic        flash_act;

    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_ff && w_ff && !s_axi_bvalid;
    assign do_read       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            aw_ff        <= 1'b0;
            w_ff         <= 1'b0;
            awaddr_ff    <= 8'h00;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_ff        <= 1'b0;
                w_ff         <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00;

    always_comb begin
        case (s_axi_araddr[7:0])
            `OFS_CURRENT_ONE:     rd_val = {24'h000000, cur_one_ff};
            `OFS_CURRENT_TWO:     rd_val = {24'h000000, current_setting_two_ff};
            `OFS_REDUCED_CURRENT: rd_val = {24'h000000, reduced_ff};
            `OFS_CONTROL:         rd_val = {20'h00000, ctl_ff};
            `OFS_LIMITS:          rd_val = {16'h0000, duration_ff};
            `OFS_ACTUAL:          rd_val = {24'h000000, actual_ff};
            `OFS_MINIMUM:         rd_val = {24'h000000, minimum_ff};
            `OFS_IRQ_STATUS:      rd_val = {28'h0000000, status_ff};
            `OFS_IRQ_MASK:        rd_val = {28'h0000000, mask_ff};
            `OFS_STATE:           rd_val = {27'h0, sink_on_out, 2'b00, mode_out};
            default:              rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= (s_axi_araddr[7:0] > `OFS_STATE || s_axi_araddr[1:0] != 2'b00)
                            ? 2'b10 : 2'b00;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge clock_in) begin
        if (reset_in || idle_fire) begin
            cur_one_ff             <= `RST_CURRENT;
            current_setting_two_ff <= `RST_CURRENT;
            reduced_ff             <= `RST_REDUCED;
            ctl_ff                 <= `RST_CONTROL;
            duration_ff            <= `RST_DURATION;
            mask_ff                <= 4'h0;
        end else if (do_write && wstrb_ff[0]) begin
            case (awaddr_ff)
                `OFS_CURRENT_ONE:     cur_one_ff <= wdata_ff[7:0];
                `OFS_CURRENT_TWO:     current_setting_two_ff <= wdata_ff[7:0];
                `OFS_REDUCED_CURRENT: reduced_ff <= wdata_ff[7:0];
                `OFS_CONTROL:         ctl_ff <= control_s'(wdata_ff[11:0]);
                `OFS_LIMITS:          duration_ff <= wdata_ff[15:0];
                `OFS_IRQ_MASK:        mask_ff <= wdata_ff[3:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // idle clock watchdog
    assign idle_fire = (idle_cnt_ff >= 32'(IDLE_CYCLES - 1)) && !pins_in.scl;
    always_ff @(posedge clock_in) begin
        if (reset_in || pins_in.scl || ctl_ff.mode == 2'b00 || !ctl_ff.out_on) begin
            idle_cnt_ff <= 32'h0000_0000;
        end else if (!idle_fire) begin
            idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
        end else begin
            idle_cnt_ff <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // flash sequencer
    logic trig_rise;
    logic tx_red;
    logic limit_hit;
    logic [7:0] target;
    assign trig_rise = pins_in.trig && !trig_d_ff;
    assign limit_hit = (units_ff >= duration_ff);
    assign tx_red    = (ctl_ff.pin_fn == 2'b01) && pins_in.txmask;
    assign flash_act = (fst_ff == st_flash);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            trig_d_ff <= 1'b0;
        end else begin
            trig_d_ff <= pins_in.trig;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || idle_fire || ctl_ff.mode != 2'b11 || !ctl_ff.out_on) begin
            fst_ff <= st_idle;
        end else begin
            case (fst_ff)
                st_idle: begin
                    if (pins_in.bat_low_pre && ctl_ff.block_lowbat) begin
                        fst_ff <= st_done;
                    end else if (ctl_ff.trig_use) begin
                        fst_ff <= st_wait_trig;
                    end else begin
                        fst_ff <= st_flash;
                    end
                end
                st_wait_trig: begin
                    if (ctl_ff.trig_level ? pins_in.trig : trig_rise) begin
                        fst_ff <= st_flash;
                    end
                end
                st_flash: begin
                    if (limit_hit || (ctl_ff.trig_use && ctl_ff.trig_level && !pins_in.trig)) begin
                        fst_ff <= st_done;
                    end
                end
                st_done: ;
                default: fst_ff <= st_idle;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || !flash_act) begin
            dur_cnt_ff <= 32'h0000_0000;
            units_ff   <= 16'h0000;
        end else if (dur_cnt_ff >= 32'(UNIT_CYCLES - 1)) begin
            dur_cnt_ff <= 32'h0000_0000;
            units_ff   <= units_ff + 16'h0001;
        end else begin
            dur_cnt_ff <= dur_cnt_ff + 32'h0000_0001;
        end
    end

    // ==========================================================
    // flash current with undervoltage stepping
    logic prelow_ff;
    assign target = (prelow_ff || tx_red) ? reduced_ff : cur_one_ff;
    always_ff @(posedge clock_in) begin
        if (reset_in || idle_fire) begin
            prelow_ff <= 1'b0;
        end else if (fst_ff == st_idle) begin
            prelow_ff <= pins_in.bat_low_pre;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || !flash_act) begin
            step_cnt_ff <= 16'h0000;
        end else if (step_cnt_ff >= 16'(STEP_CYC - 1)) begin
            step_cnt_ff <= 16'h0000;
        end else begin
            step_cnt_ff <= step_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || idle_fire) begin
            actual_ff  <= 8'h00;
            minimum_ff <= 8'hff;
        end else if (fst_ff == st_idle || fst_ff == st_wait_trig) begin
            actual_ff <= 8'h00;
        end else if (flash_act) begin
            if (actual_ff == 8'h00 && units_ff == 16'h0000 && dur_cnt_ff == 32'h0) begin
                minimum_ff <= target;
            end
            if (step_cnt_ff == 16'(STEP_CYC - 1)) begin
                if (pins_in.bat_low_run) begin
                    if (actual_ff > target) begin
                        actual_ff <= target;
                    end else if (actual_ff != 8'h00) begin
                        actual_ff  <= actual_ff - 8'h01;
                        minimum_ff <= (actual_ff - 8'h01 < minimum_ff)
                                      ? actual_ff - 8'h01 : minimum_ff;
                    end
                end else if (actual_ff < target) begin
                    actual_ff <= actual_ff + 8'h01;
                end else if (actual_ff > target) begin
                    actual_ff <= target;
                end
            end
            if (actual_ff > target) begin
                actual_ff <= target;
            end
        end
    end

    // ==========================================================
    // events and interrupt
    assign set_ev = {idle_fire,
                     flash_act && limit_hit,
                     flash_act && tx_red,
                     (fst_ff == st_idle && ctl_ff.mode == 2'b11 && ctl_ff.out_on
                      && pins_in.bat_low_pre) || (flash_act && pins_in.bat_low_run)};
    always_comb begin
        nxt_status = status_ff;
        if (do_write && awaddr_ff == `OFS_IRQ_STATUS) begin
            nxt_status = status_ff & ~wdata_ff[3:0];
        end
        nxt_status = nxt_status | set_ev;
    end
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            status_ff <= 4'h0;
        end else begin
            status_ff <= nxt_status;
        end
    end
    assign irq_out = |(status_ff & mask_ff);

    // ==========================================================
    // mode selection and sink drive
    always_ff @(posedge clock_in) begin
        if (reset_in || idle_fire || pwm_cnt_ff >= 16'(PWM_CYC - 1)) begin
            pwm_cnt_ff <= 16'h0000;
        end else begin
            pwm_cnt_ff <= pwm_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || idle_fire) begin
            sink_code_out <= 8'h00;
            sink_on_out   <= 1'b0;
            mode_out      <= mode_standby;
        end else if (ctl_ff.mode == 2'b00) begin
            mode_out      <= mode_standby;
            sink_on_out   <= (ctl_ff.pin_fn == 2'b10) && pins_in.torch;
            sink_code_out <= (ctl_ff.pin_fn == 2'b10 && pins_in.torch)
                             ? {1'b0, cur_one_ff[6:0]} : 8'h00;
        end else if (!ctl_ff.out_on) begin
            mode_out      <= mode_standby;
            sink_on_out   <= 1'b0;
            sink_code_out <= 8'h00;
        end else if (ctl_ff.mode == 2'b01) begin
            mode_out      <= mode_indicator;
            sink_code_out <= {2'b00, cur_one_ff[5:0]};
            sink_on_out   <= pwm_cnt_ff < 16'(((ctl_ff.duty + 1) * PWM_CYC) / 16);
        end else if (ctl_ff.mode == 2'b10) begin
            mode_out      <= mode_assist;
            sink_code_out <= {1'b0, cur_one_ff[6:0]};
            sink_on_out   <= 1'b1;
        end else begin
            mode_out      <= flash_act ? mode_flash : mode_standby;
            sink_code_out <= flash_act ? actual_ff : 8'h00;
            sink_on_out   <= flash_act;
        end
    end

endmodule

// ---- flash_ctrl_sva.sv ----
`timescale 1ns/1ps
module flash_ctrl_sva
    import flash_ctrl_pkg::*;
#(
    parameter int IDLE_CYCLES = 50
) (
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire pins_s       pins_in,
    input wire logic [7:0]  sink_code_out,
    input wire logic [1:0]  mode_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    int idle_cnt_ff;
    // ========
    // scl low counter
    always_ff @(posedge clock_in) begin
        if (reset_in || pins_in.scl) begin
            idle_cnt_ff <= 0;
        end else if (idle_cnt_ff < IDLE_CYCLES + 8) begin
            idle_cnt_ff <= idle_cnt_ff + 1;
        end
    end
    // ========
    // sequences and properties
    sequence s_step;
        mode_out == 2'b11 && $past(mode_out) == 2'b11 && pins_in.bat_low_run && !pins_in.txmask
            && sink_code_out != 8'h00 && sink_code_out < $past(sink_code_out);
    endsequence
    sequence s_hold_code;
        ($stable(sink_code_out) || mode_out != 2'b11)[*8];
    endsequence
    sequence s_torch_low;
        (!pins_in.torch && mode_out == 2'b00)[*3];
    endsequence
    property p_step;
        s_step |-> sink_code_out == $past(sink_code_out) - 8'h01 ##1 s_hold_code;
    endproperty
    property p_idle;
        idle_cnt_ff >= IDLE_CYCLES + 4 |-> mode_out == 2'b00;
    endproperty
    property p_indicator;
        mode_out == 2'b01 |-> sink_code_out[7:6] == 2'b00;
    endproperty
    property p_assist;
        mode_out == 2'b10 |-> !sink_code_out[7];
    endproperty
    property p_standby;
        s_torch_low |-> sink_code_out == 8'h00;
    endproperty
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_read_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_write_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_bresp;
        s_axi_bvalid |-> s_axi_bresp == 2'b00;
    endproperty
    a_step: assert property (p_step) else $error("bad low battery step");
    a_idle: assert property (p_idle) else $error("no idle shutdown");
    a_indicator: assert property (p_indicator) else $error("indicator code too wide");
    a_assist: assert property (p_assist) else $error("assist code top bit set");
    a_standby: assert property (p_standby) else $error("current in standby");
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    a_read_done: assert property (p_read_done) else $error("rvalid held after rready");
    a_write_done: assert property (p_write_done) else $error("bvalid held after bready");
    a_bresp: assert property (p_bresp) else $error("write response not okay");
endmodule
bind flash_ctrl flash_ctrl_sva #(.IDLE_CYCLES(IDLE_CYCLES)) u_sva (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .pins_in       (pins_in),
    .sink_code_out (sink_code_out),
    .mode_out      (mode_out)
);

// ---- flash_host.sv ----
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"
module flash_host (
    input  wire logic        clock_in,
    output logic [31:0]      awaddr_out,
    output logic             awvalid_out,
    input  wire logic        awready_in,
    output logic [31:0]      wdata_out,
    output logic             wvalid_out,
    input  wire logic        wready_in,
    input  wire logic        bvalid_in,
    output logic             bready_out,
    output logic [31:0]      araddr_out,
    output logic             arvalid_out,
    input  wire logic        arready_in,
    input  wire logic [31:0] rdata_in,
    input  wire logic [1:0]  rresp_in,
    input  wire logic        rvalid_in,
    output logic             rready_out,
    output logic             hang_out
);
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out, hang_out} = '0;
    end
    // ========
    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge clock_in);
        n = 0;
        awaddr_out  <= {24'h0, a};
        wdata_out   <= v;
        awvalid_out <= 1'b1;
        wvalid_out  <= 1'b1;
        bready_out  <= 1'b1;
        while (n < 1000) begin
            @(posedge clock_in);
            n++;
            if (awvalid_out && awready_in) awvalid_out <= 1'b0;
            if (wvalid_out && wready_in) wvalid_out <= 1'b0;
            if (bvalid_in) break;
        end
        bready_out <= 1'b0;
        if (n >= 1000) hang_out <= 1'b1;
    endtask
    // ========
    // register read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        int n;
        @(posedge clock_in);
        n = 0;
        araddr_out  <= {24'h0, a};
        arvalid_out <= 1'b1;
        rready_out  <= 1'b1;
        while (n < 1000) begin
            @(posedge clock_in);
            n++;
            if (arvalid_out && arready_in) arvalid_out <= 1'b0;
            if (rvalid_in) break;
        end
        v = rdata_in;
        s = rresp_in;
        rready_out <= 1'b0;
        if (n >= 1000) hang_out <= 1'b1;
    endtask
    task automatic set_current(input logic [7:0] v);
        wr(`OFS_CURRENT_ONE, {24'h0, v});
        wr(`OFS_CURRENT_TWO, {24'h0, v});
    endtask
endmodule

// ---- led_flash_mode_and_current_control_tb_top.sv ----
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"
module led_flash_mode_and_current_control_tb_top
    import flash_ctrl_pkg::*;
;
    logic        clock_in, reset_in, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, hang, sink_on, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [1:0]  bresp, rresp, r, mode;
    logic [7:0]  sink_code;
    logic [3:0]  strb = 4'hf;
    pins_s       pins;
    int          mismatches, tests_run, n;
    flash_ctrl #(.IDLE_CYCLES(50), .UNIT_CYCLES(10)) dut (
        .clock_in(clock_in), .reset_in(reset_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins_in(pins),
        .sink_code_out(sink_code), .sink_on_out(sink_on), .mode_out(mode), .irq_out(irq)
    );
    flash_host host (
        .clock_in(clock_in), .awaddr_out(awaddr), .awvalid_out(awvalid),
        .awready_in(awready), .wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready),
        .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
        .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp),
        .rvalid_in(rvalid), .rready_out(rready), .hang_out(hang)
    );
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // ========
    // checks and helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, d, r);
        chk(d, e);
    endtask
    task automatic wait_code(input logic [7:0] e, input int bound);
        for (n = 0; sink_code !== e && n < bound; n++) @(posedge clock_in);
        chk({24'h0, sink_code}, {24'h0, e});
        if (n >= bound) end_of_test();
    endtask
    task automatic rearm(input logic [31:0] c);
        host.wr(`OFS_CONTROL, 32'h0);
        host.wr(`OFS_CONTROL, c);
    endtask
    always @(posedge hang) begin
        mismatches++;
        end_of_test();
    end
    // ========
    // scenarios
    initial begin
        reset_in = 1'b1;
        pins = 6'h04;
        mismatches = 0;
        tests_run = 0;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        strb <= 4'h0;
        host.wr(`OFS_CONTROL, 32'h7);
        strb <= 4'hf;
        rdchk(`OFS_CONTROL, 32'h0);
        rdchk(`OFS_LIMITS, 32'h64);
        rdchk(`OFS_MINIMUM, 32'hff);
        host.rd(8'h40, d, r);
        chk({30'h0, r}, 32'h2);
        $display("test reset values done");
        host.set_current(8'h85);
        host.wr(`OFS_CONTROL, 32'h010);
        pins.torch <= 1'b1;
        wait_code(8'h05, 20);
        pins.torch <= 1'b0;
        wait_code(8'h00, 20);
        host.wr(`OFS_CONTROL, 32'h008);
        pins.torch <= 1'b1;
        repeat (10) @(posedge clock_in);
        chk({24'h0, sink_code}, 32'h0);
        pins.torch <= 1'b0;
        pins.txmask <= 1'b1;
        host.wr(`OFS_CONTROL, 32'h00e);
        wait_code(8'h05, 20);
        repeat (10) @(posedge clock_in);
        chk({24'h0, sink_code}, 32'h05);
        chk({30'h0, mode}, 32'h2);
        pins.txmask <= 1'b0;
        $display("test torch and assist done");
        host.set_current(8'hff);
        host.wr(`OFS_CONTROL, 32'h305);
        wait_code(8'h3f, 20);
        n = 0;
        repeat (3200) @(posedge clock_in) if (sink_on === 1'b1) n++;
        chk(n, 800);
        pins.scl <= 1'b0;
        repeat (60) @(posedge clock_in);
        chk({30'h0, mode}, 32'h0);
        chk({24'h0, sink_code}, 32'h0);
        pins.scl <= 1'b1;
        rdchk(`OFS_CONTROL, 32'h0);
        rdchk(`OFS_CURRENT_ONE, 32'h0);
        rdchk(`OFS_IRQ_STATUS, 32'h8);
        host.wr(`OFS_IRQ_MASK, 32'h8);
        repeat (2) @(posedge clock_in);
        chk({31'h0, irq}, 32'h1);
        host.wr(`OFS_IRQ_STATUS, 32'h8);
        repeat (2) @(posedge clock_in);
        chk({31'h0, irq}, 32'h0);
        $display("test indicator and timeout done");
        host.wr(`OFS_LIMITS, 32'h400);
        host.wr(`OFS_REDUCED_CURRENT, 32'h02);
        host.set_current(8'h10);
        pins.bat_low_pre <= 1'b1;
        host.wr(`OFS_CONTROL, 32'h087);
        repeat (900) @(posedge clock_in);
        chk({24'h0, sink_code}, 32'h0);
        chk({30'h0, mode}, 32'h0);
        rdchk(`OFS_IRQ_STATUS, 32'h1);
        rearm(32'h007);
        wait_code(8'h02, 2000);
        repeat (1000) @(posedge clock_in);
        chk({24'h0, sink_code}, 32'h02);
        pins.bat_low_pre <= 1'b0;
        $display("test prestart battery done");
        rearm(32'h00f);
        wait_code(8'h04, 4000);
        pins.txmask <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk({24'h0, sink_code}, 32'h02);
        rdchk(`OFS_ACTUAL, 32'h02);
        host.rd(`OFS_IRQ_STATUS, d, r);
        chk(d & 32'h2, 32'h2);
        pins.txmask <= 1'b0;
        $display("test txmask done");
        host.set_current(8'h04);
        rearm(32'h007);
        wait_code(8'h04, 4000);
        pins.bat_low_run <= 1'b1;
        wait_code(8'h03, 900);
        for (n = 0; sink_code === 8'h03 && n < 900; n++) @(posedge clock_in);
        chk(n, 800);
        pins.bat_low_run <= 1'b0;
        repeat (1700) @(posedge clock_in);
        chk({31'h0, sink_code >= 8'h02}, 32'h1);
        for (n = 0; mode === 2'b11 && n < 6000; n++) @(posedge clock_in);
        chk({31'h0, n < 6000}, 32'h1);
        rdchk(`OFS_MINIMUM, 32'h02);
        host.rd(`OFS_IRQ_STATUS, d, r);
        chk(d & 32'h1, 32'h1);
        $display("test runtime battery done");
        rearm(32'h027);
        repeat (900) @(posedge clock_in);
        chk({24'h0, sink_code}, 32'h0);
        pins.trig <= 1'b1;
        wait_code(8'h01, 900);
        rearm(32'h067);
        wait_code(8'h01, 900);
        pins.trig <= 1'b0;
        wait_code(8'h00, 20);
        $display("test trigger done");
        end_of_test();
    end
endmodule
